/* File: verif/adc_setup_avg_pin_config_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  err_count++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module adc_setup_avg_pin_config_regs_test;
  logic        sys_clk = 1'b0, rst = 1'b1, sample_done = 1'b0;
  logic        min_intr, max_intr, data_ready, companion_req;
  logic        device_ready_flag, wr_en, ref_use_supply, scaling_active;
  logic        mux_analog, mux_half_supply, chopping_signal;
  logic        pin0_out, pin0_oe_n, pin1_out, pin1_oe_n;
  logic [1:0]  operating_mode, pin0_route, pin1_route;
  logic [3:0]  chopping_window_code;
  logic [7:0]  addr, wdata, rdata, exp_r, exp_q[$];
  logic [12:0] average_ratio;
  logic [31:0] seed = 32'd90180;
  int          err_count = 0, total_checks = 0, i;
  event        got;
  adc_setup_avg_pin_config_regs u_dut (.*);
  cfg_host_model u_host (.*);
  always #2.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected {oe_n, level}; chop idle low, pin0 code 7 floats
  function automatic logic [1:0] pf(input logic [2:0] f, input logic p0,
                                    input logic pol);
    logic [1:0] rt;
    rt = p0 ? pin0_route : pin1_route;
    case (f)
      3'h1: pf = {1'b0, |(rt & {max_intr, min_intr})};
      3'h2: pf = {1'b0, data_ready};
      3'h3: pf = {1'b0, companion_req ~^ pol};
      3'h6: pf = 2'b01;
      3'h7: pf = p0 ? 2'b10 : {1'b0, device_ready_flag};
      default: pf = (f == 3'h0) ? 2'b10 : 2'b00;
    endcase
  endfunction
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse();
    sample_done = 1'b1;
    @(posedge sys_clk) #1;
    sample_done = 1'b0;
    settle();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a);
    exp_q.push_back(e);
    @(posedge sys_clk) #1;
    -> got;
  endtask
  // Reads are judged apart from the driver, oldest first
  always @(got) begin
    exp_r = exp_q.pop_front();
    `CHK(rdata, exp_r)
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog well beyond the roughly 500 cycles needed
  initial begin
    #60000;
    err_count++;
    end_sim();
  end
  initial begin
    {operating_mode, pin0_route, pin1_route, chopping_window_code} = 10'h0;
    {min_intr, max_intr, data_ready, companion_req} = 4'h0;
    device_ready_flag = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 rst = 1'b0;
    rdc(8'h22, 8'h00);
    rdc(8'h23, 8'h00);
    rdc(8'h24, 8'hF0);
    rdc(8'h30, 8'h00);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      u_host.wr(8'h22, {2'b11, i[0], 3'b111, i[1:0]});
      settle();
      `CHK(ref_use_supply, i[0])
      `CHK({mux_analog, mux_half_supply}, {i == 0, i == 2})
      `CHK(scaling_active, i == 0)
      rdc(8'h22, {2'b00, i[0], 3'b100, i[1:0]});
    end
    $display("setup test done");
    for (i = 0; i < 64; i++) begin
      operating_mode = i[5:4];
      seed = lfsr(seed);
      u_host.wr(8'h23, {seed[7:4], i[3:0]});
      settle();
      `CHK(average_ratio, (i[5:4] inside {1, 2} && i[3:0] < 12) ? 13'h2 << i[3:0] : 13'h0)
      rdc(8'h23, {4'h0, i[3:0]});
    end
    $display("averaging test done");
    for (i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      {min_intr, max_intr, data_ready, companion_req} = seed[3:0];
      {device_ready_flag, pin0_route, pin1_route} = seed[8:4];
      // One code on both pins keeps chop and companion apart
      u_host.wr(8'h24, {i[3], i[2:0], 1'b0, i[2:0]});
      settle();
      `CHK({pin1_oe_n, pin1_out & ~pin1_oe_n}, pf(i[2:0], 0, i[3]))
      `CHK({pin0_oe_n, pin0_out & ~pin0_oe_n}, pf(i[2:0], 1, i[3]))
    end
    $display("pin test done");
    chopping_window_code = 4'h1;
    u_host.wr(8'h24, 8'hE8);
    settle();
    pulse();
    `CHK(chopping_signal, 1'b0)
    pulse();
    `CHK({chopping_signal, pin1_out}, 2'b10)
    rst = 1'b1;
    settle();
    rst = 1'b0;
    rdc(8'h24, 8'hF0);
    $display("chop and reset test done");
    end_sim();
  end
endmodule
`default_nettype wire

/* File: verif/cfg_bank_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cfg_bank_monitor (
  input wire logic        sys_clk,        // Clock
  input wire logic        rst,            // Reset
  input wire logic        wr_en,          // Write
  input wire logic [7:0]  addr,           // Address
  input wire logic [7:0]  wdata,          // Data in
  input wire logic [7:0]  rdata,          // Data out
  input wire logic [1:0]  operating_mode, // Mode
  input wire logic        ref_use_supply, // Reference
  input wire logic        scaling_active, // Scaling
  input wire logic        mux_analog,     // Analog in
  input wire logic [12:0] average_ratio,  // Ratio
  input wire logic        pin0_oe_n,      // Pin0 enable
  input wire logic        pin1_out,       // Pin1 level
  input wire logic        pin1_oe_n       // Pin1 enable
);
  // Lone writes: derived outputs land two edges later
  wire w22 = wr_en && addr == 8'h22;
  wire w24 = wr_en && addr == 8'h24;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_ref_select: assert property (
    w22 ##1 !w22 |=> ref_use_supply == $past(wdata[5], 2))
    else $error("reference select wrong");
  a_scale_gate: assert property (
    scaling_active |-> mux_analog) else $error("scaling off inputs");
  a_ratio_pow2: assert property (
    average_ratio == 0 || ($onehot(average_ratio) && !average_ratio[0]))
    else $error("ratio not a power of two");
  a_ratio_mode: assert property (
    average_ratio != 0 |-> $past(operating_mode) inside {2'h1, 2'h2})
    else $error("ratio outside averaging");
  a_static_level: assert property (
    w24 && wdata[6:4] inside {3'h5, 3'h6} && !wdata[3] ##1 !w24 |=>
    !pin1_oe_n && pin1_out == $past(wdata[5], 2))
    else $error("static level wrong");
  a_pin0_float: assert property (
    w24 && wdata[2:0] inside {3'h0, 3'h7} ##1 !w24 |=> pin0_oe_n)
    else $error("pin0 driven");
  a_unmapped_zero: assert property (
    !(addr inside {[8'h22:8'h24]}) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (
    addr == 8'h22 |=> (rdata & 8'hCC) == 8'h00)
    else $error("reserved bits set");
  a_reset_state: assert property (disable iff (1'b0)
    rst |=> rdata == 8'h00 && pin0_oe_n && !scaling_active)
    else $error("reset state wrong");
endmodule
bind adc_setup_avg_pin_config_regs cfg_bank_monitor u_mon (.*);
`default_nettype wire

/* File: verif/cfg_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side: one byte a cycle, changed just after an edge
module cfg_host_model (
  input  wire logic       sys_clk, // Clock
  output var  logic       wr_en,   // Write strobe
  output var  logic [7:0] addr,    // Address
  output var  logic [7:0] wdata    // Write data
);
  initial begin
    wr_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // Released data is inverted so no stale byte lingers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(posedge sys_clk) #1;
    wr_en = 1'b0;
    wdata = ~d;
  endtask
  // Address held for the registered read
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk) #1;
    addr = a;
  endtask
endmodule
`default_nettype wire

/* File: verilog/adc_setup_avg_pin_config_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bank_regs.vh"
// How it works
// (R1) Setup bit 5 picks reference pin or supply
// (R2) Scaling only when enabled and on analog inputs
// (R3) Mux code 0 analog, 2 half supply
// (R4) Host measures reference to supply ratio
// (R5) Averaging ratio is two to code plus one
// (R6) Ratio applies to continuous and burst modes
// (R7) Bit 7 sets companion enable polarity
// (R8) Pin1 function field routes eight sources
// (R9) Pin0 same codes, code 7 invalid
// (R10) Codes 5 and 6 drive static levels
// (R11) Bit 3 enables invert on chop
// (R12) Host never enables chop and companion together
// (R13) Reset values 0x00, 0x00, 0xF0
// (R14) Mode 1 burst, mode 2 continuous averaging
// (R15) Pin0 interrupt from routed threshold flags
// (R16) Chop toggles after window of samples
// (R17) Reserved writes ignored, invalid codes harmless
module adc_setup_avg_pin_config_regs (
  input  wire        sys_clk,          // 200 MHz clock
  input  wire        rst,              // Sync reset, active high
  input  wire        wr_en,            // Register write strobe
  input  wire [7:0]  addr,             // Register address
  input  wire [7:0]  wdata,            // Write data
  output wire [7:0]  rdata,            // Read data, one cycle later
  input  wire [1:0]  operating_mode,   // Operating mode select
  input  wire [1:0]  pin0_route,       // Pin0 interrupt route
  input  wire [1:0]  pin1_route,       // Pin1 interrupt route
  input  wire [3:0]  chopping_window_code, // Chop window code
  input  wire        min_intr,         // Minimum threshold event
  input  wire        max_intr,         // Maximum threshold event
  input  wire        data_ready,       // Data ready level
  input  wire        companion_req,    // Companion enable request
  input  wire        sample_done,      // One pulse per conversion
  input  wire        device_ready_flag, // Device ready level
  output reg         ref_use_supply,   // Reference from supply
  output reg         scaling_active,   // monitor_value scaling on
  output reg         mux_analog,       // Converter on analog inputs
  output reg         mux_half_supply,  // Converter on half supply
  output reg  [12:0] average_ratio,    // Averaging ratio, 0 if idle
  output reg         chopping_signal,  // Chop state
  output reg         pin0_out,         // Pin0 output level
  output reg         pin0_oe_n,        // Pin0 enable, low drives
  output reg         pin1_out,         // Pin1 output level
  output reg         pin1_oe_n         // Pin1 enable, low drives
);
  wire [7:0] setup_q;
  wire [7:0] avg_q;
  wire [7:0] pin_q;
  reg  [`CHOP_CNT_W-1:0] chop_cnt;
  reg  [`CHOP_CNT_W-1:0] chop_limit;
  reg        comp_level;
  reg        pin0_intr;
  reg        pin1_intr;
  reg        next_pin0;
  reg        next_pin0_oe_n;
  reg        next_pin1;
  reg        next_pin1_oe_n;

  // Usage notes for the next person on this block:
  // - Register writes reach the derived outputs two edges later,
  //   one edge for the store and one for the output flops.
  // - Invalid multiplexer codes leave both mux outputs low, so the
  //   converter path is parked rather than left half-connected.
  // - Pin0 code 7 floats the pin; pin1 code 7 shows device ready.
  // - Chop and companion on one pin pair is the host's duty to
  //   avoid; nothing here arbitrates between them.
  // - Averaging ratio reads zero outside the two averaging modes,
  //   which keeps the downstream filter idle in other modes.
  // - The chop counter only advances on sample pulses, so a slow
  //   sample rate stretches the chop period with it.

  cfg_reg_store u_store (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_en   (wr_en),
    .addr    (addr),
    .wdata   (wdata),
    .rdata   (rdata),
    .setup_q (setup_q),
    .avg_q   (avg_q),
    .pin_q   (pin_q)
  );

  // Threshold flag selection shared by both pins
  function route_sel;
    input [1:0] route;
    input       mn;
    input       mx;
    begin
      case (route)
        `ROUTE_MIN:    route_sel = mn;
        `ROUTE_MAX:    route_sel = mx;
        `ROUTE_EITHER: route_sel = mn | mx;
        default:       route_sel = 1'b0;
      endcase
    end
  endfunction

  // Pin function decode; returns {oe_n, level}
  function [1:0] pin_fn;
    input [2:0] code;
    input       intr;
    input       invalid7;
    begin
      case (code)
        `FN_INTR:       pin_fn = {1'b0, intr};
        `FN_DATA_READY: pin_fn = {1'b0, data_ready};
        `FN_COMPANION:  pin_fn = {1'b0, comp_level};
        `FN_CHOP:       pin_fn = {1'b0, chopping_signal};
        `FN_LOW:        pin_fn = 2'h0;              // [R10]
        `FN_HIGH:       pin_fn = 2'h1;              // [R10]
        `FN_DEV_READY:  pin_fn = invalid7 ? 2'h2    // [R9] [R17]
                                  : {1'b0, device_ready_flag};
        default:        pin_fn = 2'h2;              // High impedance
      endcase
    end
  endfunction

  // Companion polarity and interrupt routing
  always @* begin
    comp_level = pin_q[`BIT_POLARITY] ? companion_req
                                      : ~companion_req;   // [R7]
    pin0_intr  = route_sel(pin0_route, min_intr, max_intr);  // [R15]
    pin1_intr  = route_sel(pin1_route, min_intr, max_intr);
    {next_pin1_oe_n, next_pin1} =
      pin_fn(pin_q[`PIN1_MSB:`PIN1_LSB], pin1_intr, 1'b0);  // [R8]
    {next_pin0_oe_n, next_pin0} =
      pin_fn(pin_q[`PIN0_MSB:`PIN0_LSB], pin0_intr, 1'b1);  // [R9]
  end

  // Chop window length; codes above 11 use the full counter range
  always @* begin
    if (chopping_window_code > `AVG_MAX_CODE)
      chop_limit = {`CHOP_CNT_W{1'b1}};
    else
      chop_limit = ({{(`CHOP_CNT_W-1){1'b0}}, 1'b1}
                    << chopping_window_code) - 1'b1;
  end

  // Setup decode; reset matches the cleared setup register
  always @(posedge sys_clk) begin
    if (rst) begin
      ref_use_supply  <= 1'b0;
      scaling_active  <= 1'b0;
      mux_analog      <= 1'b1;
      mux_half_supply <= 1'b0;
      average_ratio   <= 13'h0000;
    end else begin
      ref_use_supply  <= setup_q[`BIT_REF_SELECT];                // [R1]
      mux_analog      <= setup_q[`MUX_MSB:0] == `MUX_ANALOG;      // [R3]
      mux_half_supply <= setup_q[`MUX_MSB:0] == `MUX_HALF_SUPPLY; // [R3] [R4]
      scaling_active  <= setup_q[`BIT_SCALE_EN] &&
                         setup_q[`MUX_MSB:0] == `MUX_ANALOG;      // [R2]
      // Ratio only meaningful in the two averaging modes
      if ((operating_mode == `MODE_BURST_AVG ||
           operating_mode == `MODE_CONT_AVG) &&
          avg_q[`AVG_MSB:0] <= `AVG_MAX_CODE)                     // [R14]
        average_ratio <= 13'h0002 << avg_q[`AVG_MSB:0];          // [R5] [R6]
      else
        average_ratio <= 13'h0000;
    end
  end

  // Chop timer; kept apart so pin logic sees a clean level
  always @(posedge sys_clk) begin
    if (rst) begin
      chopping_signal <= 1'b0;
      chop_cnt        <= {`CHOP_CNT_W{1'b0}};
    end else begin
      // Toggle after the programmed count of samples
      if (sample_done) begin
        if (chop_cnt >= chop_limit) begin
          chop_cnt        <= {`CHOP_CNT_W{1'b0}};
          chopping_signal <= ~chopping_signal;                    // [R16]
        end else begin
          chop_cnt <= chop_cnt + 1'b1;
        end
      end
    end
  end

  // Pin drivers; pins float during reset to avoid bus fights
  always @(posedge sys_clk) begin
    if (rst) begin
      pin0_out  <= 1'b0;
      pin0_oe_n <= 1'b1;
      pin1_out  <= 1'b0;
      pin1_oe_n <= 1'b1;
    end else begin
      // Invert-on-chop flips driven levels while chop is high
      pin0_out  <= next_pin0 ^ (pin_q[`BIT_INVERT_CHOP]
                   & chopping_signal & ~next_pin0_oe_n);          // [R11]
      pin0_oe_n <= next_pin0_oe_n;
      pin1_out  <= next_pin1 ^ (pin_q[`BIT_INVERT_CHOP]
                   & chopping_signal & ~next_pin1_oe_n);          // [R11]
      pin1_oe_n <= next_pin1_oe_n;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/cfg_bank_regs.vh */
`ifndef CFG_BANK_REGS_VH
`define CFG_BANK_REGS_VH
`define ADDR_ADC_SETUP        8'h22
`define ADDR_AVERAGING_WINDOW 8'h23
`define ADDR_GENERAL_PIN      8'h24
`define RST_ADC_SETUP         8'h00
`define RST_AVERAGING_WINDOW  8'h00
`define RST_GENERAL_PIN       8'hF0
`define MASK_ADC_SETUP        8'h33
`define MASK_AVERAGING_WINDOW 8'h0F
`define MASK_GENERAL_PIN      8'hFF
`define BIT_REF_SELECT        5
`define BIT_SCALE_EN          4
`define MUX_MSB               1
`define MUX_ANALOG            2'h0
`define MUX_HALF_SUPPLY       2'h2
`define AVG_MSB               3
`define AVG_MAX_CODE          4'hB
`define BIT_POLARITY          7
`define PIN1_MSB              6
`define PIN1_LSB              4
`define BIT_INVERT_CHOP       3
`define PIN0_MSB              2
`define PIN0_LSB              0
`define FN_HIGHZ              3'h0
`define FN_INTR               3'h1
`define FN_DATA_READY         3'h2
`define FN_COMPANION          3'h3
`define FN_CHOP               3'h4
`define FN_LOW                3'h5
`define FN_HIGH               3'h6
`define FN_DEV_READY          3'h7
`define MODE_BURST_AVG        2'h1
`define MODE_CONT_AVG         2'h2
`define ROUTE_MIN             2'h1
`define ROUTE_MAX             2'h2
`define ROUTE_EITHER          2'h3
`define CHOP_CNT_W            12
`endif

/* File: verilog/cfg_reg_store.v */
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bank_regs.vh"
// Three-byte register store; read data registered
module cfg_reg_store (
  input  wire       sys_clk,  // Clock
  input  wire       rst,      // Sync reset
  input  wire       wr_en,    // Write strobe
  input  wire [7:0] addr,     // Register address
  input  wire [7:0] wdata,    // Write data
  output reg  [7:0] rdata,    // Registered read data
  output reg  [7:0] setup_q,  // adc_setup
  output reg  [7:0] avg_q,    // averaging_window
  output reg  [7:0] pin_q     // general_pin_setup
);
  // Reserved bits masked at write so they always read zero
  always @(posedge sys_clk) begin
    if (rst) begin
      setup_q <= `RST_ADC_SETUP;            // [R13]
      avg_q   <= `RST_AVERAGING_WINDOW;     // [R13]
      pin_q   <= `RST_GENERAL_PIN;          // [R13] [R7] [R8] [R9] [R11]
      rdata   <= 8'h00;
    end else begin
      if (wr_en && addr == `ADDR_ADC_SETUP)
        setup_q <= wdata & `MASK_ADC_SETUP;       // [R17]
      if (wr_en && addr == `ADDR_AVERAGING_WINDOW)
        avg_q <= wdata & `MASK_AVERAGING_WINDOW;  // [R17]
      if (wr_en && addr == `ADDR_GENERAL_PIN)
        pin_q <= wdata;
      case (addr)
        `ADDR_ADC_SETUP:        rdata <= setup_q;
        `ADDR_AVERAGING_WINDOW: rdata <= avg_q;
        `ADDR_GENERAL_PIN:      rdata <= pin_q;
        default:                rdata <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire
